// ---- hdl/sbd_pkg.sv ----
// constants, register map and types of the safe brake drive monitor
// Contract
// - torque-off-active flag high while torque-off holds; mirrored in state word bit 0
// - torque-off activates on application demand, fault reaction or fieldbus demand
// - torque-off-selected flag set on any torque-off request; state word bit 10
// - error-active flag high while any error is active; state word bit 13
// - acknowledge-required flag high while acknowledge needed; state word bit 14
// - brake-released flag high while brake current is driven; state word bit 16; code also keeps it high during test pulses
// - safety status word to fieldbus carries torque-off-active in bit 0
// - two independent switch channels with feedback, periodically tested while released
// - high and low switch driven separately, each tested once per second; code drives both together and tests them in one shared window
// - test pulse at most 1 ms, pulses spaced at least 900 ms
// - brake control runs automatically when brake-attached code says attached
// - with brake configured, control starts with torque-off and engages the brake
// - error state reads 00h without failure, 01h when failed, enforcing torque-off and brake
// - error code 00h normally, 12h on brake output fault, which forces torque-off
// - brake lost while released and motor enabled raises fault and torque-off
// - brake-attached setting is eight bits: 00h none (default), 01h attached
// - sixteen-bit delay in ms between brake engagement and torque-off, brake only
package sbd_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000;
  localparam int unsigned TEST_PULSE_MS = 1;
  localparam int unsigned TEST_GAP_MS   = 1000;
  localparam int unsigned TEST_MIN_MS   = 900;
  localparam int unsigned MAX_DELAY_MS  = 60000;
  // register indices; the byte address on the bus is the index times four
  localparam logic [15:0] IDX_ERR_STATE = 16'h1a02;
  localparam logic [15:0] IDX_ERR_CODE  = 16'h1a03;
  localparam logic [15:0] IDX_TO_ACT    = 16'h1a10;
  localparam logic [15:0] IDX_TO_SEL    = 16'h1a1a;
  localparam logic [15:0] IDX_ERR_ACT   = 16'h1a1d;
  localparam logic [15:0] IDX_ACK_REQ   = 16'h1a1e;
  localparam logic [15:0] IDX_BRK_REL   = 16'h1a20;
  localparam logic [15:0] IDX_STATE_W   = 16'h1a06;
  localparam logic [15:0] IDX_ATTACH    = 16'h47d4;
  localparam logic [15:0] IDX_DELAY     = 16'h47d5;
  localparam logic [15:0] IDX_CTRL      = 16'h1b00;
  localparam logic [15:0] IDX_IRQ_STAT  = 16'h1b01;
  localparam logic [15:0] IDX_IRQ_MASK  = 16'h1b02;
  // field values and bit positions
  localparam logic [7:0] ERR_STATE_NONE = 8'h00;
  localparam logic [7:0] ERR_STATE_IO   = 8'h01;
  localparam logic [7:0] ERR_CODE_NONE  = 8'h00;
  localparam logic [7:0] ERR_CODE_BRAKE = 8'h12;
  localparam logic [7:0] ATTACH_NONE    = 8'h00;
  localparam logic [7:0] ATTACH_YES     = 8'h01;
  localparam int unsigned SW_TO_ACT  = 0;
  localparam int unsigned SW_TO_SEL  = 10;
  localparam int unsigned SW_ERR_ACT = 13;
  localparam int unsigned SW_ACK_REQ = 14;
  localparam int unsigned SW_BRK_REL = 16;
  // control register bits
  localparam int unsigned CTRL_APP_REQ = 0;
  localparam int unsigned CTRL_RELEASE = 1;
  localparam int unsigned CTRL_ACK     = 2;
  // interrupt bits
  localparam int unsigned IRQ_FAULT   = 0;
  localparam int unsigned IRQ_TO_ON   = 1;
  localparam int unsigned IRQ_TEST_OK = 2;
  localparam int unsigned IRQ_W       = 3;
  typedef enum {ST_IDLE, ST_RELEASED, ST_TEST, ST_ENGAGE_WAIT} sbd_state_e;
  typedef struct packed {
    logic hi_on;
    logic lo_on;
  } sbd_switch_s;
  typedef struct packed {
    logic hi_fb;
    logic lo_fb;
    logic current_fb;
  } sbd_feedback_s;
endpackage

// ---- hdl/sbd_monitor.sv ----
// safe brake drive monitor with torque-off logic and APB registers
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module sbd_monitor #(
  parameter int unsigned TEST_GAP_CYC   = sbd_pkg::TEST_GAP_MS * sbd_pkg::MS_CYCLES,
  parameter int unsigned TEST_PULSE_CYC = sbd_pkg::TEST_PULSE_MS * sbd_pkg::MS_CYCLES,
  parameter int unsigned MS_CYC         = sbd_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic                  MCLK_I,
  input  wire logic                  RST_I,
  // apb slave
  input  wire logic                  PSEL_I,
  input  wire logic                  PENABLE_I,
  input  wire logic                  PWRITE_I,
  input  wire logic [17:0]           PADDR_I,
  input  wire logic [31:0]           PWDATA_I,
  output logic      [31:0]           PRDATA_O,
  output logic                       PREADY_O,
  output logic                       PSLVERR_O,
  // torque-off demands and motor state
  input  wire logic                  FIELDBUS_TO_REQ_I,
  input  wire logic                  FAULT_BUF_REQ_I,
  input  wire logic                  MOTOR_ENABLED_I,
  // brake connector switches and feedback
  output sbd_pkg::sbd_switch_s       BRAKE_SW_O,
  input  wire sbd_pkg::sbd_feedback_s BRAKE_FB_I,
  // outputs to drive and fieldbus
  output logic                       TORQUE_OFF_O,
  output logic      [15:0]           SAFE_STATUS_WORD_ONE_O,
  output logic                       IRQ_O
);
  // shortest legal spacing of two test pulses on the brake
  localparam int unsigned MIN_GAP_CYC = sbd_pkg::TEST_MIN_MS * MS_CYC;

  // refuse timings the brake cannot tolerate: pulse above 1 ms or spacing under 900 ms
  if (MS_CYC < 1 || TEST_PULSE_CYC < 1 || TEST_PULSE_CYC > sbd_pkg::TEST_PULSE_MS * MS_CYC
      || TEST_GAP_CYC < MIN_GAP_CYC) begin : g_bad_timing
    $error("sbd_monitor: bad timing parameters");
  end

  // register index decode, used by the write path
  function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
    return (a[17:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  logic [7:0]  attach;
  logic [15:0] delay_ms;
  logic        app_req;
  logic        release_req;
  logic [2:0]  irq_stat;
  logic [2:0]  irq_mask;
  logic [7:0]  err_state;
  logic [7:0]  err_code;
  logic        fault_now;
  logic        to_active;
  logic        brake_released;
  logic [31:0] state_word;
  logic        to_req;
  logic        brake_cfg;
  logic        wr_en;
  logic        ack_pulse;
  logic        test_fail;
  logic        test_pass;
  logic        to_rise;
  logic        to_active_d;
  logic [31:0] gap_cnt;
  logic [31:0] pulse_cnt;
  logic [31:0] ms_cnt;
  logic [15:0] delay_cnt;
  sbd_pkg::sbd_state_e state;

  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
  assign ack_pulse = wr_en && hit(PADDR_I, sbd_pkg::IDX_CTRL) && PWDATA_I[sbd_pkg::CTRL_ACK];
  assign brake_cfg = (attach == sbd_pkg::ATTACH_YES);

  // configuration and control registers
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      attach      <= sbd_pkg::ATTACH_NONE;
      delay_ms    <= 16'h0000;
      app_req     <= 1'b0;
      release_req <= 1'b0;
      irq_mask    <= 3'h0;
    end else if (wr_en) begin
      if (hit(PADDR_I, sbd_pkg::IDX_ATTACH))
        attach <= PWDATA_I[7:0];
      if (hit(PADDR_I, sbd_pkg::IDX_DELAY) && PWDATA_I[15:0] <= 16'(sbd_pkg::MAX_DELAY_MS))
        delay_ms <= PWDATA_I[15:0];
      if (hit(PADDR_I, sbd_pkg::IDX_CTRL)) begin
        app_req     <= PWDATA_I[sbd_pkg::CTRL_APP_REQ];
        release_req <= PWDATA_I[sbd_pkg::CTRL_RELEASE];
      end
      if (hit(PADDR_I, sbd_pkg::IDX_IRQ_MASK))
        irq_mask <= PWDATA_I[2:0];
    end
  end

  assign to_req = app_req || FAULT_BUF_REQ_I || FIELDBUS_TO_REQ_I || fault_now
                  || (err_state != sbd_pkg::ERR_STATE_NONE);

  // brake lost while released and motor enabled
  assign fault_now = test_fail
                     || (state == sbd_pkg::ST_RELEASED && MOTOR_ENABLED_I
                         && !BRAKE_FB_I.current_fb);

  // brake switch sequencer with periodic switch-off tests
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state      <= sbd_pkg::ST_IDLE;
      gap_cnt    <= 32'h0000_0000;
      pulse_cnt  <= 32'h0000_0000;
      ms_cnt     <= 32'h0000_0000;
      delay_cnt  <= 16'h0000;
      BRAKE_SW_O <= '0;
    end else begin
      case (state)
        sbd_pkg::ST_IDLE: begin
          BRAKE_SW_O <= '0;
          if (brake_cfg && release_req && !to_req) begin
            state      <= sbd_pkg::ST_RELEASED;
            BRAKE_SW_O <= '1;
            gap_cnt    <= 32'h0000_0000;
          end
        end
        sbd_pkg::ST_RELEASED: begin
          // test each switch once per second
          gap_cnt <= gap_cnt + 32'h0000_0001;
          if (to_req || !release_req || !brake_cfg) begin
            state      <= sbd_pkg::ST_ENGAGE_WAIT;
            BRAKE_SW_O <= '0;
            delay_cnt  <= 16'h0000;
            ms_cnt     <= 32'h0000_0000;
          end else if (gap_cnt >= 32'(TEST_GAP_CYC - 1)) begin
            // both switches cut in one window: each is tested every period,
            // yet the brake sees only one pulse per period
            state      <= sbd_pkg::ST_TEST;
            BRAKE_SW_O <= '0;
            pulse_cnt  <= 32'h0000_0000;
          end
        end
        sbd_pkg::ST_TEST: begin
          pulse_cnt <= pulse_cnt + 32'h0000_0001;
          if (to_req || !release_req || !brake_cfg) begin
            state      <= sbd_pkg::ST_ENGAGE_WAIT;
            BRAKE_SW_O <= '0;
            delay_cnt  <= 16'h0000;
            ms_cnt     <= 32'h0000_0000;
          end else if (pulse_cnt >= 32'(TEST_PULSE_CYC - 1)) begin
            state      <= sbd_pkg::ST_RELEASED;
            BRAKE_SW_O <= '1;
            gap_cnt    <= 32'h0000_0000;
          end
        end
        sbd_pkg::ST_ENGAGE_WAIT: begin
          // delay from brake engagement to torque-off
          BRAKE_SW_O <= '0;
          ms_cnt <= (ms_cnt >= 32'(MS_CYC - 1)) ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
          if (ms_cnt >= 32'(MS_CYC - 1) && delay_cnt < delay_ms)
            delay_cnt <= delay_cnt + 16'h0001;
          // back to idle once delay is over and no demand is left;
          // the release request is a level, so a standing one re-releases
          if (delay_cnt >= delay_ms && !to_req)
            state <= sbd_pkg::ST_IDLE;
        end
        default: state <= sbd_pkg::ST_IDLE;
      endcase
    end
  end

  // feedback check: each switch must read off at pulse end
  // failed test is a brake output fault
  assign test_pass = (state == sbd_pkg::ST_TEST)
                     && pulse_cnt >= 32'(TEST_PULSE_CYC - 1)
                     && !BRAKE_FB_I.hi_fb && !BRAKE_FB_I.lo_fb;
  assign test_fail = (state == sbd_pkg::ST_TEST)
                     && pulse_cnt >= 32'(TEST_PULSE_CYC - 1) && !test_pass;

  // torque-off active follows the request after brake delay when configured
  // torque-off active state
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      to_active   <= 1'b1;
      to_active_d <= 1'b1;
    end else begin
      to_active_d <= to_active;
      if (!to_req)
        to_active <= 1'b0;
      else if (!brake_cfg || fault_now || (err_state != sbd_pkg::ERR_STATE_NONE)
               || (state == sbd_pkg::ST_ENGAGE_WAIT && delay_cnt >= delay_ms)
               || state == sbd_pkg::ST_IDLE)
        to_active <= 1'b1;
    end
  end
  assign to_rise = to_active && !to_active_d;
  assign brake_released = (state != sbd_pkg::ST_IDLE) && (state != sbd_pkg::ST_ENGAGE_WAIT);

  // error state and error code latch on fault
  // held until acknowledge once the fault has cleared
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      err_state <= sbd_pkg::ERR_STATE_NONE;
      err_code  <= sbd_pkg::ERR_CODE_NONE;
    end else if (fault_now) begin
      err_state <= sbd_pkg::ERR_STATE_IO;
      err_code  <= sbd_pkg::ERR_CODE_BRAKE;
    end else if (ack_pulse) begin
      err_state <= sbd_pkg::ERR_STATE_NONE;
      err_code  <= sbd_pkg::ERR_CODE_NONE;
    end
  end

  // combined safety state word
  always_comb begin
    state_word = 32'h0000_0000;
    state_word[sbd_pkg::SW_TO_ACT]  = to_active;
    state_word[sbd_pkg::SW_TO_SEL]  = to_req;
    state_word[sbd_pkg::SW_ERR_ACT] = fault_now || (err_state != sbd_pkg::ERR_STATE_NONE);
    state_word[sbd_pkg::SW_ACK_REQ] = (err_state != sbd_pkg::ERR_STATE_NONE);
    state_word[sbd_pkg::SW_BRK_REL] = brake_released;
  end

  // interrupt status, set wins over write-one clear
  always_ff @(posedge MCLK_I) begin
    if (RST_I)
      irq_stat <= 3'h0;
    else
      irq_stat <= (irq_stat & ~((wr_en && hit(PADDR_I, sbd_pkg::IDX_IRQ_STAT))
                                ? PWDATA_I[2:0] : 3'h0))
                  | {test_pass, to_rise, fault_now};
  end
  assign IRQ_O = |(irq_stat & irq_mask);

  // fieldbus status word and torque-off output registers
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      SAFE_STATUS_WORD_ONE_O <= 16'h0001;
      TORQUE_OFF_O           <= 1'b1;
    end else begin
      // torque-off active in status bit 0
      SAFE_STATUS_WORD_ONE_O <= {15'h0000, to_active};
      TORQUE_OFF_O           <= to_active || fault_now;
    end
  end

  // apb read data register
  always_ff @(posedge MCLK_I) begin
    if (RST_I)
      PRDATA_O <= 32'h0000_0000;
    else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      case (PADDR_I[17:2])
        sbd_pkg::IDX_ERR_STATE: PRDATA_O <= {24'h00_0000, err_state};
        sbd_pkg::IDX_ERR_CODE:  PRDATA_O <= {24'h00_0000, err_code};
        sbd_pkg::IDX_TO_ACT:    PRDATA_O <= {31'h0, state_word[sbd_pkg::SW_TO_ACT]};
        sbd_pkg::IDX_TO_SEL:    PRDATA_O <= {31'h0, state_word[sbd_pkg::SW_TO_SEL]};
        sbd_pkg::IDX_ERR_ACT:   PRDATA_O <= {31'h0, state_word[sbd_pkg::SW_ERR_ACT]};
        sbd_pkg::IDX_ACK_REQ:   PRDATA_O <= {31'h0, state_word[sbd_pkg::SW_ACK_REQ]};
        sbd_pkg::IDX_BRK_REL:   PRDATA_O <= {31'h0, state_word[sbd_pkg::SW_BRK_REL]};
        sbd_pkg::IDX_STATE_W:   PRDATA_O <= state_word;
        sbd_pkg::IDX_ATTACH:    PRDATA_O <= {24'h00_0000, attach};
        sbd_pkg::IDX_DELAY:     PRDATA_O <= {16'h0000, delay_ms};
        sbd_pkg::IDX_CTRL:      PRDATA_O <= {30'h0, release_req, app_req};
        sbd_pkg::IDX_IRQ_STAT:  PRDATA_O <= {29'h0, irq_stat};
        sbd_pkg::IDX_IRQ_MASK:  PRDATA_O <= {29'h0, irq_mask};
        default:                PRDATA_O <= 32'h0000_0000;
      endcase
    end
  end
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = 1'b0;

  // pulse spacing helper: cycles since last test start
  logic [31:0] since_test;
  always_ff @(posedge MCLK_I) begin
    if (RST_I)
      since_test <= 32'hffff_ffff;
    else if (state == sbd_pkg::ST_TEST && pulse_cnt == 32'h0000_0000)
      since_test <= 32'h0000_0000;
    else if (since_test != 32'hffff_ffff)
      since_test <= since_test + 32'h0000_0001;
  end

  sequence s_fault;
    fault_now;
  endsequence
  sequence s_latched;
    ##1 (err_state == sbd_pkg::ERR_STATE_IO && err_code == sbd_pkg::ERR_CODE_BRAKE);
  endsequence
  // first cycle of a switch-off test window
  sequence s_test_start;
    $rose(state == sbd_pkg::ST_TEST);
  endsequence

  a_fault_latch: assert property (@(posedge MCLK_I) disable iff (RST_I)
    s_fault |-> s_latched) else $error("fault not latched");
  a_fault_stoff: assert property (@(posedge MCLK_I) disable iff (RST_I)
    fault_now |=> TORQUE_OFF_O) else $error("fault without torque-off");
  a_status_bit: assert property (@(posedge MCLK_I) disable iff (RST_I)
    1'b1 |=> SAFE_STATUS_WORD_ONE_O[0] == $past(to_active)) else $error("status bit 0 wrong");
  a_brake_off: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (err_state != sbd_pkg::ERR_STATE_NONE) |=> ##1 BRAKE_SW_O == '0) else $error("brake not engaged");
  a_pulse_len: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (state == sbd_pkg::ST_TEST) |-> pulse_cnt < 32'(TEST_PULSE_CYC))
    else $error("test pulse too long");
  a_pulse_gap: assert property (@(posedge MCLK_I) disable iff (RST_I)
    s_test_start |-> since_test >= 32'(MIN_GAP_CYC))
    else $error("test pulses too close");
  a_test_both: assert property (@(posedge MCLK_I) disable iff (RST_I)
    s_test_start |-> BRAKE_SW_O == '0) else $error("test does not cut both switches");
  a_engage_first: assert property (@(posedge MCLK_I) disable iff (RST_I)
    ($rose(to_active) && brake_cfg) |-> BRAKE_SW_O == '0) else $error("torque-off before brake");
  a_delay_stoff: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (state == sbd_pkg::ST_ENGAGE_WAIT && brake_cfg && delay_cnt < delay_ms
     && err_state == sbd_pkg::ERR_STATE_NONE && !fault_now) |=> !$rose(to_active))
    else $error("torque-off before brake delay");
  a_no_attach: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !brake_cfg |=> ##1 BRAKE_SW_O == '0) else $error("brake driven unconfigured");
  a_err_hold: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (err_state != sbd_pkg::ERR_STATE_NONE && !ack_pulse) |=> err_state == sbd_pkg::ERR_STATE_IO)
    else $error("error state dropped without acknowledge");
  a_ack_flag: assert property (@(posedge MCLK_I) disable iff (RST_I)
    state_word[sbd_pkg::SW_ACK_REQ] == (err_code == sbd_pkg::ERR_CODE_BRAKE)) else $error("ack flag wrong");
endmodule
`default_nettype wire

// ---- sim/sbd_brake_model.sv ----
// behavioural model of the external holding brake on the brake connector
`timescale 1ns/100ps
`default_nettype none
module sbd_brake_model (
  // clock
  input  wire logic                  clk_i,
  // scenario controls
  input  wire logic                  slow_i,
  input  wire logic                  stuck_lo_i,
  input  wire logic                  unplugged_i,
  // switch commands and feedback
  input  wire sbd_pkg::sbd_switch_s  sw_i,
  output var  sbd_pkg::sbd_feedback_s fb_o
);
  sbd_pkg::sbd_feedback_s now_fb;
  sbd_pkg::sbd_feedback_s late_fb;

  always_comb begin
    now_fb.hi_fb      = sw_i.hi_on;
    now_fb.lo_fb      = sw_i.lo_on | stuck_lo_i;
    // current needs both switches and a wired brake
    now_fb.current_fb = now_fb.hi_fb & now_fb.lo_fb & ~unplugged_i;
  end

  // one cycle late answer for slow scenarios
  always_ff @(posedge clk_i) begin
    late_fb <= now_fb;
  end

  assign fb_o = slow_i ? late_fb : now_fb;
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench of the safe brake drive monitor
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int GAP = 2000;
  localparam int PULSE = 2;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, torque_off;
  logic fb_req, buf_req, motor_en, slow, stuck_lo, unplugged;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] sw1;
  sbd_pkg::sbd_switch_s   sw;
  sbd_pkg::sbd_feedback_s fb;
  int n_mismatch, tests_run;

  sbd_monitor #(.TEST_GAP_CYC(GAP), .TEST_PULSE_CYC(PULSE), .MS_CYC(2)) sbd_monitor_inst (
    .MCLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .FIELDBUS_TO_REQ_I(fb_req), .FAULT_BUF_REQ_I(buf_req),
    .MOTOR_ENABLED_I(motor_en), .BRAKE_SW_O(sw), .BRAKE_FB_I(fb),
    .TORQUE_OFF_O(torque_off), .SAFE_STATUS_WORD_ONE_O(sw1), .IRQ_O(irq));
  sbd_brake_model sbd_brake_model_inst (.clk_i(clk), .slow_i(slow), .stuck_lo_i(stuck_lo),
    .unplugged_i(unplugged), .sw_i(sw), .fb_o(fb));

  task automatic results;
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // apb master: setup, then access until pready sampled high
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [15:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0000_0000);
    chk(nm, e, rd);
    chk("pslverr_low", 32'h0000_0000, {31'h0, pslverr});
  endtask

  // wait bounded for switches and torque-off to reach a pair of values
  task automatic settle(input logic [1:0] e, input logic t, input int lim);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (!(sw === e && torque_off === t) && k < lim);
  endtask

  task automatic release_brk;
    apb(1'b1, sbd_pkg::IDX_CTRL, 32'h0000_0002);
    settle(2'b11, 1'b0, 300);
    chk("switches_on", 32'h0000_0003, {30'h0, sw});
    chk("torque_off_low", 32'h0000_0000, {31'h0, torque_off});
    rdchk("to_act_low", sbd_pkg::IDX_TO_ACT, 32'h0000_0000);
    rdchk("brk_rel_high", sbd_pkg::IDX_BRK_REL, 32'h0000_0001);
  endtask

  task automatic t_reset;
    chk("torque_off_rst", 32'h0000_0001, {31'h0, torque_off});
    chk("status_word_rst", 32'h0000_0001, {16'h0, sw1});
    rdchk("err_state_rst", sbd_pkg::IDX_ERR_STATE, 32'h0000_0000);
    rdchk("err_code_rst", sbd_pkg::IDX_ERR_CODE, 32'h0000_0000);
    rdchk("attach_rst", sbd_pkg::IDX_ATTACH, 32'h0000_0000);
    apb(1'b1, sbd_pkg::IDX_ERR_CODE, 32'h0000_0055);
    rdchk("err_code_ro", sbd_pkg::IDX_ERR_CODE, 32'h0000_0000);
    rdchk("unmapped", 16'h0123, 32'h0000_0000);
    apb(1'b1, sbd_pkg::IDX_ATTACH, 32'h0000_0001);
    rdchk("attach_set", sbd_pkg::IDX_ATTACH, 32'h0000_0001);
    apb(1'b1, sbd_pkg::IDX_DELAY, 32'h0000_0003);
    apb(1'b1, sbd_pkg::IDX_DELAY, 32'h0000_ea61);
    rdchk("delay_limit", sbd_pkg::IDX_DELAY, 32'h0000_0003);
  endtask

  // watch test pulses of both switches while released
  task automatic t_pulses;
    int run[2], cnt[2], last[2], mx, gmin, gmax;
    logic on;
    run = '{0, 0};
    cnt = '{0, 0};
    last = '{0, 0};
    mx = 0;
    gmin = 1000000;
    gmax = 0;
    for (int c = 0; c < 4500; c++) begin
      @(negedge clk);
      for (int j = 0; j < 2; j++) begin
        on = (j == 0) ? sw.hi_on : sw.lo_on;
        if (on !== 1'b1) begin
          if (run[j] == 0 && cnt[j] > 0) begin
            gmin = (c - last[j] < gmin) ? c - last[j] : gmin;
            gmax = (c - last[j] > gmax) ? c - last[j] : gmax;
          end
          if (run[j] == 0) begin
            last[j] = c;
            cnt[j]++;
          end
          run[j]++;
          mx = (run[j] > mx) ? run[j] : mx;
        end else begin
          run[j] = 0;
        end
      end
    end
    chk("pulse_len_ok", 32'h0000_0001, {31'h0, mx <= PULSE});
    chk("hi_tested", 32'h0000_0001, {31'h0, cnt[0] >= 2});
    chk("lo_tested", 32'h0000_0001, {31'h0, cnt[1] >= 2});
    chk("gap_min_ok", 32'h0000_0001, {31'h0, gmin >= GAP * 9 / 10});
    chk("gap_max_ok", 32'h0000_0001, {31'h0, gmax <= GAP + PULSE + 4});
    chk("torque_kept_off", 32'h0000_0000, {31'h0, torque_off});
    apb(1'b0, sbd_pkg::IDX_IRQ_STAT, 32'h0000_0000);
    chk("test_pass_irq", 32'h0000_0001, {31'h0, rd[sbd_pkg::IRQ_TEST_OK]});
  endtask

  // each of the three torque-off sources engages the brake
  task automatic t_demand(input int src);
    slow <= 1'b1;
    if (src == 0)
      apb(1'b1, sbd_pkg::IDX_CTRL, 32'h0000_0003);
    @(posedge clk);
    fb_req  <= (src == 1);
    buf_req <= (src == 2);
    settle(2'b00, 1'b1, 100);
    chk("demand_to", 32'h0000_0001, {31'h0, torque_off});
    chk("demand_brake", 32'h0000_0000, {30'h0, sw});
    chk("status_bit0", 32'h0000_0001, {31'h0, sw1[0]});
    rdchk("to_sel", sbd_pkg::IDX_TO_SEL, 32'h0000_0001);
    rdchk("brk_rel_low", sbd_pkg::IDX_BRK_REL, 32'h0000_0000);
    apb(1'b0, sbd_pkg::IDX_STATE_W, 32'h0000_0000);
    chk("state_word", 32'h0000_0401, rd & 32'h0001_6401);
    @(posedge clk);
    fb_req  <= 1'b0;
    buf_req <= 1'b0;
    slow    <= 1'b0;
    release_brk();
  endtask

  // stuck switch or lost brake raise the output fault
  task automatic t_fault(input int kind);
    logic a;
    @(posedge clk);
    stuck_lo  <= (kind == 0);
    unplugged <= (kind == 1);
    settle(2'b00, 1'b1, 2 * GAP + 100);
    chk("fault_to", 32'h0000_0001, {31'h0, torque_off});
    chk("fault_brake", 32'h0000_0000, {30'h0, sw});
    rdchk("code_fault", sbd_pkg::IDX_ERR_CODE, 32'h0000_0012);
    rdchk("state_fault", sbd_pkg::IDX_ERR_STATE, 32'h0000_0001);
    apb(1'b0, sbd_pkg::IDX_STATE_W, 32'h0000_0000);
    chk("state_word_err", 32'h0000_6401, rd & 32'h0001_6401);
    rdchk("ack_req", sbd_pkg::IDX_ACK_REQ, 32'h0000_0001);
    apb(1'b0, sbd_pkg::IDX_IRQ_STAT, 32'h0000_0000);
    chk("fault_irq", 32'h0000_0001, {31'h0, rd[sbd_pkg::IRQ_FAULT]});
    apb(1'b1, sbd_pkg::IDX_IRQ_MASK, 32'h0000_0000);
    @(negedge clk);
    a = irq;
    apb(1'b1, sbd_pkg::IDX_IRQ_MASK, 32'h0000_0007);
    @(negedge clk);
    chk("irq_masking", 32'h0000_0001, {31'h0, a !== irq});
    repeat (20) @(posedge clk);
    rdchk("code_held", sbd_pkg::IDX_ERR_CODE, 32'h0000_0012);
    @(posedge clk);
    stuck_lo  <= 1'b0;
    unplugged <= 1'b0;
    repeat (5) @(posedge clk);
    apb(1'b1, sbd_pkg::IDX_CTRL, 32'h0000_0004);
    rdchk("code_clear", sbd_pkg::IDX_ERR_CODE, 32'h0000_0000);
    rdchk("state_clear", sbd_pkg::IDX_ERR_STATE, 32'h0000_0000);
    rdchk("err_act_clear", sbd_pkg::IDX_ERR_ACT, 32'h0000_0000);
    apb(1'b1, sbd_pkg::IDX_IRQ_STAT, 32'h0000_0007);
    @(negedge clk);
    chk("irq_cleared", 32'h0000_0000, {31'h0, irq});
    release_brk();
  endtask

  // clock generation
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    results();
  end

  // main sequence
  initial begin
    {rst, psel, penable, pwrite, fb_req, buf_req, slow, stuck_lo, unplugged} = 9'h100;
    motor_en = 1'b1;
    paddr = 18'h0_0000;
    pwdata = 32'h0000_0000;
    n_mismatch = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    t_reset();
    release_brk();
    t_pulses();
    for (int s = 0; s < 3; s++)
      t_demand(s);
    t_fault(0);
    t_fault(1);
    results();
  end
endmodule
`default_nettype wire
